// ### verilog/sleep_ctl_regs.svh
// offsets, field positions, reset values and timing counts of the sleep controller
// assumes word addressing on the register bus (one 32-bit word per index)
`ifndef SLEEP_CTL_REGS_SVH
`define SLEEP_CTL_REGS_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_SMC   2'h0
`define IDX_CMP   2'h1
`define IDX_T2M   2'h2
`define IDX_STAT  2'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define SMC_SE_BIT    0
`define SMC_MODE_LSB  1
`define SMC_MODE_MSB  3
`define CMP_DIS_BIT   7
`define T2M_OVF_BIT   0
`define T2M_CMP_BIT   1
// ----------------------------------------
// reset values
// ----------------------------------------
`define SMC_RST  4'h0
`define T2M_RST  2'h0
// ----------------------------------------
// mode codes
// ----------------------------------------
`define MODE_IDLE  3'h0
`define MODE_NR    3'h1
`define MODE_PD    3'h2
`define MODE_PS    3'h3
`define MODE_STBY  3'h6
// ----------------------------------------
// timing counts, in clock cycles
// ----------------------------------------
`define WAKE_HALT_CK   4'h4
`define PD_STARTUP_CK  4'h6
`define STBY_WAKE_CK   4'h6
`endif

// ### verilog/sleep_ctl_pkg.sv
// types shared by the sleep controller
// assumes nothing beyond the regs header
package sleep_ctl_pkg;
  typedef enum logic [1:0] {PH_ACTIVE, PH_SLEEP, PH_START, PH_HALT} phase_t;

  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic tmr_osc;
    logic t2_sync;
  } dom_t;

  typedef struct packed {
    phase_t     phase;
    logic [2:0] mode;
    logic       rst_wake;
    logic [3:0] cnt;
    logic [3:0] smc;
    logic       cmp_on;
    logic [1:0] t2m;
    logic       waitreq;
    logic [7:0] rdata;
    dom_t       dom;
    logic       stall;
    logic       adc_start;
    logic       rst_vec;
    logic       resume;
    logic       retain;
    logic       asleep;
  } st_t;
endpackage

// ### verilog/sleep_ctl.sv
// sleep-mode controller: mode registers, clock-domain gating, wake-up sequencing
// assumes inputs synchronous to mclk; reset sources reset the core elsewhere
module sleep_ctl (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sleep_instr,
  input  wire logic        sys_reset_req,
  input  wire logic        global_int_en,
  input  wire logic        ext_external_interrupt_zero_irq,
  input  wire logic        external_interrupt_zero_is_level,
  input  wire logic        pin_change_irq,
  input  wire logic        usi_start_irq,
  input  wire logic        t2_ovf_irq,
  input  wire logic        t2_cmp_irq,
  input  wire logic        t2_async,
  input  wire logic        t2_running,
  input  wire logic        spm_ready_irq,
  input  wire logic        adc_done_irq,
  input  wire logic        adc_enabled,
  input  wire logic        cmp_irq,
  input  wire logic        other_io_irq,
  input  wire logic        ext_crystal,
  output logic             core_clk_en,
  output logic             flash_clk_en,
  output logic             io_clk_en,
  output logic             adc_clk_en,
  output logic             async_clk_en,
  output logic             main_osc_en,
  output logic             timer_osc_en,
  output logic             t2_sync_clk_en,
  output logic             core_stall,
  output logic             adc_conv_start,
  output logic             reset_vector_req,
  output logic             irq_resume,
  output logic             cmp_pwr_en,
  output logic             mem_retain,
  output logic             sleeping
);
  `include "sleep_ctl_regs.svh"

  sleep_ctl_pkg::st_t s_q;
  sleep_ctl_pkg::st_t s_d;

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  // standby without a crystal falls back to power-down
  function automatic logic [2:0] eff_mode(input logic [2:0] m, input logic xtal);
    eff_mode = (m == `MODE_STBY && !xtal) ? `MODE_PD : m;
  endfunction

  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m == `MODE_IDLE) || (m == `MODE_NR) || (m == `MODE_PD) ||
              (m == `MODE_PS) || (m == `MODE_STBY);
  endfunction

  function automatic sleep_ctl_pkg::dom_t dom_for(input logic [2:0] m, input logic asy,
                                                  input logic run);
    sleep_ctl_pkg::dom_t d;
    d = '0;
    case (m)
      `MODE_IDLE: begin
        d.io       = 1'b1;
        d.adc      = 1'b1;
        d.asy      = 1'b1;
        d.main_osc = 1'b1;
        d.tmr_osc  = asy;
      end
      `MODE_NR: begin
        d.adc      = 1'b1;
        d.asy      = 1'b1;
        d.main_osc = 1'b1;
        d.tmr_osc  = asy;
      end
      `MODE_PS: begin
        d.asy     = 1'b1;
        d.tmr_osc = asy;
        // sync clock for timer two only
        d.t2_sync = run && !asy;
      end
      `MODE_STBY: d.main_osc = 1'b1;
      default: d = '0;
    endcase
    dom_for = d;
  endfunction

  // counts are loaded minus one; the start phase lasts count cycles, at least one
  function automatic logic [3:0] startup_cnt(input logic [2:0] m);
    case (m)
      `MODE_PD, `MODE_PS: startup_cnt = `PD_STARTUP_CK - 4'h1;
      `MODE_STBY:         startup_cnt = `STBY_WAKE_CK - 4'h1;
      default:            startup_cnt = 4'h0;
    endcase
  endfunction

  // ----------------------------------------
  // wake sources
  // ----------------------------------------
  logic t2_irq;
  logic external_interrupt_zero_lvl;
  logic async_src;
  logic wake_hit;

  always_comb begin
    t2_irq    = global_int_en && ((t2_ovf_irq && s_q.t2m[`T2M_OVF_BIT]) ||
                                  (t2_cmp_irq && s_q.t2m[`T2M_CMP_BIT]));
    external_interrupt_zero_lvl  = ext_external_interrupt_zero_irq && external_interrupt_zero_is_level;
    async_src = usi_start_irq || pin_change_irq || external_interrupt_zero_lvl;
    case (s_q.mode)
      `MODE_IDLE: wake_hit = async_src || ext_external_interrupt_zero_irq || (t2_irq && t2_async) ||
                             spm_ready_irq || adc_done_irq || other_io_irq ||
                             (cmp_irq && s_q.cmp_on);
      `MODE_NR:   wake_hit = async_src || (t2_irq && t2_async) || spm_ready_irq ||
                             adc_done_irq;
      `MODE_PS:   wake_hit = async_src || (t2_irq && (t2_async || s_q.dom.t2_sync));
      default:    wake_hit = async_src;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [2:0] req_mode;

  always_comb begin
    s_d           = s_q;
    req_mode      = eff_mode(s_q.smc[`SMC_MODE_MSB:`SMC_MODE_LSB], ext_crystal);
    s_d.adc_start = 1'b0;
    s_d.rst_vec   = 1'b0;
    s_d.resume    = 1'b0;
    s_d.waitreq   = 1'b1;
    s_d.retain    = 1'b1;

    // one wait cycle, then a single low-waitrequest cycle per access
    if ((avs_read || avs_write) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      case (avs_address)
        `IDX_SMC:  s_d.rdata = {4'h0, s_q.smc};
        `IDX_CMP:  s_d.rdata = {!s_q.cmp_on, 7'h00};
        `IDX_T2M:  s_d.rdata = {6'h00, s_q.t2m};
        default:   s_d.rdata = {s_q.phase, s_q.mode, s_q.rst_wake, s_q.stall, 1'b0};
      endcase
    end
    if (avs_write && !s_q.waitreq) begin
      case (avs_address)
        `IDX_SMC: s_d.smc    = avs_writedata[3:0];
        `IDX_CMP: s_d.cmp_on = !avs_writedata[`CMP_DIS_BIT];
        `IDX_T2M: s_d.t2m    = avs_writedata[1:0];
        default:  s_d.smc    = s_q.smc;
      endcase
    end

    case (s_q.phase)
      sleep_ctl_pkg::PH_ACTIVE: begin
        if (sleep_instr && s_q.smc[`SMC_SE_BIT] && mode_ok(req_mode)) begin
          s_d.phase = sleep_ctl_pkg::PH_SLEEP;
          s_d.mode  = req_mode;
          s_d.dom   = dom_for(req_mode, t2_async, t2_running);
          s_d.adc_start = adc_enabled &&
                          (req_mode == `MODE_IDLE || req_mode == `MODE_NR);
        end
      end
      sleep_ctl_pkg::PH_SLEEP: begin
        s_d.dom = dom_for(s_q.mode, t2_async, t2_running);
        if (sys_reset_req || wake_hit) begin
          s_d.phase        = sleep_ctl_pkg::PH_START;
          s_d.rst_wake     = sys_reset_req;
          s_d.cnt          = startup_cnt(s_q.mode);
          s_d.dom.main_osc = 1'b1;
        end
      end
      sleep_ctl_pkg::PH_START: begin
        if (sys_reset_req) begin
          s_d.rst_wake = 1'b1;
        end
        if (s_q.cnt == 4'h0) begin
          s_d.dom = '{core: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1,
                      main_osc: 1'b1, tmr_osc: t2_async, t2_sync: 1'b0};
          if (s_q.rst_wake || sys_reset_req) begin
            s_d.rst_vec = 1'b1;
            s_d.phase   = sleep_ctl_pkg::PH_ACTIVE;
          end else begin
            s_d.stall = 1'b1;
            s_d.cnt   = `WAKE_HALT_CK - 4'h1;
            s_d.phase = sleep_ctl_pkg::PH_HALT;
          end
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      sleep_ctl_pkg::PH_HALT: begin
        if (s_q.cnt == 4'h0) begin
          s_d.stall  = 1'b0;
          s_d.resume = 1'b1;
          s_d.phase  = sleep_ctl_pkg::PH_ACTIVE;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: s_d.phase = sleep_ctl_pkg::PH_ACTIVE;
    endcase
    // registered so the status pin is not a decode
    s_d.asleep = (s_d.phase == sleep_ctl_pkg::PH_SLEEP);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // clock enable low freezes everything, the bus handshake included
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.phase    <= sleep_ctl_pkg::PH_ACTIVE;
      s_q.smc      <= `SMC_RST;
      s_q.t2m      <= `T2M_RST;
      s_q.cmp_on   <= 1'b1;
      s_q.waitreq  <= 1'b1;
      s_q.retain   <= 1'b1;
      s_q.dom      <= 8'hFF;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign avs_readdata     = {24'h000000, s_q.rdata};
  assign avs_waitrequest  = s_q.waitreq;
  assign core_clk_en      = s_q.dom.core;
  assign flash_clk_en     = s_q.dom.flash;
  assign io_clk_en        = s_q.dom.io;
  assign adc_clk_en       = s_q.dom.adc;
  assign async_clk_en     = s_q.dom.asy;
  assign main_osc_en      = s_q.dom.main_osc;
  assign timer_osc_en     = s_q.dom.tmr_osc;
  assign t2_sync_clk_en   = s_q.dom.t2_sync;
  assign core_stall       = s_q.stall;
  assign adc_conv_start   = s_q.adc_start;
  assign reset_vector_req = s_q.rst_vec;
  assign irq_resume       = s_q.resume;
  assign cmp_pwr_en       = s_q.cmp_on;
  assign mem_retain       = s_q.retain;
  assign sleeping         = s_q.asleep;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_NO_SLEEP_WITHOUT_SE: assert property (
    clk_en && s_q.phase == sleep_ctl_pkg::PH_ACTIVE && !s_q.smc[`SMC_SE_BIT]
    |=> s_q.phase != sleep_ctl_pkg::PH_SLEEP)
    else $error("sleep entered without enable bit");

  AST_HALT_FOUR: assert property (
    clk_en && s_q.phase == sleep_ctl_pkg::PH_START && s_q.cnt == 4'h0 &&
    !s_q.rst_wake && !sys_reset_req ##1 clk_en [*5]
    |-> $past(core_stall, 4) && !core_stall && irq_resume && !$past(irq_resume))
    else $error("wake halt not four cycles");

  AST_RESET_WAKE: assert property (
    clk_en && sleeping && sys_reset_req
    |=> s_q.phase == sleep_ctl_pkg::PH_START && s_q.rst_wake)
    else $error("reset did not wake");

  AST_IDLE_DOMAINS: assert property (
    sleeping && s_q.mode == `MODE_IDLE
    |-> !core_clk_en && !flash_clk_en && io_clk_en && adc_clk_en && async_clk_en)
    else $error("idle clock domains wrong");

  AST_ADC_START: assert property (
    clk_en && s_q.phase == sleep_ctl_pkg::PH_ACTIVE && sleep_instr &&
    s_q.smc == {`MODE_NR, 1'b1} && adc_enabled
    |=> adc_conv_start ##1 !adc_conv_start || !clk_en)
    else $error("no conversion on noise reduction entry");

  AST_NR_DOMAINS: assert property (
    sleeping && s_q.mode == `MODE_NR
    |-> !io_clk_en && !core_clk_en && !flash_clk_en && adc_clk_en)
    else $error("noise reduction domains wrong");

  AST_PD_DOMAINS: assert property (
    sleeping && s_q.mode == `MODE_PD |-> s_q.dom == 8'h00)
    else $error("power-down left a clock running");

  AST_EDGE_EXTERNAL_INTERRUPT_ZERO_NO_WAKE: assert property (
    clk_en && sleeping && s_q.mode == `MODE_PD && ext_external_interrupt_zero_irq && !external_interrupt_zero_is_level &&
    !usi_start_irq && !pin_change_irq && !sys_reset_req
    |=> sleeping)
    else $error("edge external_interrupt_zero woke power-down");

  AST_PS_T2_WAKE: assert property (
    clk_en && sleeping && s_q.mode == `MODE_PS && t2_async && global_int_en &&
    t2_ovf_irq && s_q.t2m[`T2M_OVF_BIT]
    |=> s_q.phase == sleep_ctl_pkg::PH_START)
    else $error("timer two did not wake power-save");

  AST_STBY_SIX: assert property (
    clk_en && sleeping && s_q.mode == `MODE_STBY && (pin_change_irq || usi_start_irq)
    |=> main_osc_en && s_q.cnt == 4'h5)
    else $error("standby wake count wrong");

  AST_CMP_OFF: assert property (
    clk_en && sleeping && s_q.mode == `MODE_IDLE && !s_q.cmp_on && cmp_irq &&
    !ext_external_interrupt_zero_irq && !usi_start_irq && !pin_change_irq && !spm_ready_irq &&
    !adc_done_irq && !other_io_irq && !sys_reset_req && !t2_ovf_irq && !t2_cmp_irq
    |=> sleeping)
    else $error("disabled comparator woke idle");

  AST_TMR_OSC_ASYNC: assert property (
    sleeping && !$past(t2_async) |-> !timer_osc_en)
    else $error("timer oscillator on without async timer two");

  AST_PS_SYNC_ONLY: assert property (
    sleeping && (s_q.mode != `MODE_PS || $past(t2_async)) |-> !t2_sync_clk_en)
    else $error("synchronous timer clock on without synchronous timer two");

  AST_NR_NO_IO_WAKE: assert property (
    clk_en && sleeping && s_q.mode == `MODE_NR && other_io_irq && !usi_start_irq && !pin_change_irq &&
    !external_interrupt_zero_lvl && !spm_ready_irq && !adc_done_irq && !t2_ovf_irq && !t2_cmp_irq && !sys_reset_req
    |=> sleeping)
    else $error("io interrupt woke noise reduction");

  AST_RESET_VECTOR: assert property (
    clk_en && s_q.phase == sleep_ctl_pkg::PH_START && s_q.cnt == 4'h0 && s_q.rst_wake
    |=> reset_vector_req && core_clk_en && !core_stall && !sleeping)
    else $error("reset wake missed the reset vector");
endmodule

// ### verif/core_model.sv
// core stand-in: issues the sleep instruction and tracks where execution resumes
// assumes sleep_ctl outputs on mclk; go is a one-cycle request from the bench
module core_model (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       go,
  input  wire logic       core_clk_en,
  input  wire logic       reset_vector_req,
  input  wire logic       irq_resume,
  output logic            sleep_instr,
  output logic [7:0]      pc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ret_q;
  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_instr <= 1'b0;
      pc          <= 8'h00;
      ret_q       <= 8'h00;
    end else begin
      // sleep only from a running core
      sleep_instr <= go & core_clk_en;
      if (go & core_clk_en) begin
        ret_q <= 8'h41;
        pc    <= 8'hFF;
      end
      if (reset_vector_req) begin
        pc <= 8'h00;
      end else if (irq_resume) begin
        pc <= ret_q;
      end
    end
  end
endmodule

// ### verif/testbench.sv
// self-checking bench: register bus, mode entry, clock gating, wake-up timing
// assumes core_model as the core; wake sources driven directly by the bench
`include "sleep_ctl_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, arst_n, go, avs_read, avs_write, avs_waitrequest, sleep_instr;
  logic [1:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [6:0]  wsrc;
  logic        sys_reset_req, global_int_en, external_interrupt_zero_is_level, t2_async, adc_enabled, ext_crystal;
  logic        core_clk_en, flash_clk_en, io_clk_en, adc_clk_en, async_clk_en, main_osc_en, timer_osc_en;
  logic        t2_sync_clk_en, core_stall, adc_conv_start, reset_vector_req, irq_resume, cmp_pwr_en;
  logic        mem_retain, sleeping;
  logic [7:0]  pc;
  int          miscompares, checked, conv_cnt, c0, n, stl;
  logic [2:0]  mcode [5] = '{`MODE_IDLE, `MODE_NR, `MODE_PD, `MODE_PS, `MODE_STBY};
  logic [6:0]  dexp [5] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02};
  int          start [5] = '{1, 1, 6, 6, 6};

  sleep_ctl sleep_ctl_inst (
    .mclk(mclk), .arst_n(arst_n), .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sleep_instr(sleep_instr), .sys_reset_req(sys_reset_req),
    .global_int_en(global_int_en), .ext_external_interrupt_zero_irq(wsrc[5]), .external_interrupt_zero_is_level(external_interrupt_zero_is_level),
    .pin_change_irq(wsrc[2]), .usi_start_irq(wsrc[4]), .t2_ovf_irq(wsrc[3]), .t2_cmp_irq(1'b0),
    .t2_async(t2_async), .t2_running(1'b1), .spm_ready_irq(1'b0), .adc_done_irq(wsrc[1]),
    .adc_enabled(adc_enabled), .cmp_irq(wsrc[6]), .other_io_irq(wsrc[0]), .ext_crystal(ext_crystal),
    .core_clk_en(core_clk_en), .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en),
    .async_clk_en(async_clk_en), .main_osc_en(main_osc_en), .timer_osc_en(timer_osc_en),
    .t2_sync_clk_en(t2_sync_clk_en), .core_stall(core_stall), .adc_conv_start(adc_conv_start),
    .reset_vector_req(reset_vector_req), .irq_resume(irq_resume), .cmp_pwr_en(cmp_pwr_en),
    .mem_retain(mem_retain), .sleeping(sleeping)
  );
  core_model core_model_inst (
    .mclk(mclk), .arst_n(arst_n), .go(go), .core_clk_en(core_clk_en), .reset_vector_req(reset_vector_req),
    .irq_resume(irq_resume), .sleep_instr(sleep_instr), .pc(pc)
  );
  // ----------------------------------------
  // clock and conversion-start counter
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (adc_conv_start === 1'b1) conv_cnt <= conv_cnt + 1;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bus request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (k == 20) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic rdc(input string what, input logic [1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic enter(input logic [3:0] smc, input logic exp_sleep);
    bus(1'b1, `IDX_SMC, {28'h0, smc});
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("sleeping", exp_sleep, sleeping);
  endtask
  // the level stays up until the core resumes, long enough to be seen
  task automatic wake(input int b, input int exp_n);
    @(posedge mclk);
    wsrc[b] <= 1'b1; // level held
    n = 0;
    stl = 0;
    while (irq_resume !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
      if (core_stall === 1'b1) stl++;
    end
    if (n == 40) begin
      miscompares++;
      report_and_stop();
    end
    @(posedge mclk);
    wsrc[b] <= 1'b0;
    @(negedge mclk);
    chk("wake cycles", exp_n, n);
    chk("stall cycles", 4, stl);
    chk("resume point", 8'h41, pc);
    chk("retain", 1, mem_retain);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {arst_n, go, avs_read, avs_write, sys_reset_req, external_interrupt_zero_is_level} = '0;
    {avs_address, avs_writedata, wsrc} = '0;
    {global_int_en, t2_async, adc_enabled, ext_crystal} = 4'hF;
    {miscompares, checked} = '0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    rdc("mode ctl reset", `IDX_SMC, 32'h0);
    rdc("t2 mask reset", `IDX_T2M, 32'h0);
    bus(1'b1, `IDX_STAT, 32'hFF);
    rdc("status read-only", `IDX_STAT, 32'h0);
    bus(1'b1, `IDX_T2M, 32'h1);
    rdc("t2 mask", `IDX_T2M, 32'h1);
    enter({`MODE_IDLE, 1'b0}, 1'b0);
    enter({3'h4, 1'b1}, 1'b0);
    for (int i = 0; i < 5; i++) begin
      c0 = conv_cnt;
      enter({mcode[i], 1'b1}, 1'b1);
      chk("domains", dexp[i], {core_clk_en, flash_clk_en, io_clk_en, adc_clk_en, async_clk_en, main_osc_en,
          timer_osc_en});
      if (i == 3) chk("t2 sync clock", 0, t2_sync_clk_en);
      if (i == 1) begin
        @(posedge mclk);
        wsrc[0] <= 1'b1;
        repeat (3) @(negedge mclk);
        chk("nr io no wake", 1, sleeping);
        @(posedge mclk);
        wsrc[0] <= 1'b0;
      end
      wake(i, start[i] + 6); // all five modes, each by its own source
      chk("conv starts", i < 2, conv_cnt - c0);
    end
    // power-down ignores idle and noise-reduction sources and edge-triggered external_interrupt_zero
    enter({`MODE_PD, 1'b1}, 1'b1);
    rdc("mode ctl", `IDX_SMC, {28'h0, `MODE_PD, 1'b1});
    bus(1'b0, `IDX_STAT, 32'h0);
    chk("status", 32'h50, rd & 32'hFE);
    @(posedge mclk);
    wsrc <= 7'h63;
    repeat (10) @(negedge mclk);
    chk("still asleep", 1, sleeping);
    @(posedge mclk);
    wsrc <= 7'h00;
    sys_reset_req <= 1'b1;
    n = 0;
    while (reset_vector_req !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20) begin
      miscompares++;
      report_and_stop();
    end
    @(posedge mclk);
    sys_reset_req <= 1'b0;
    @(negedge mclk);
    chk("reset vector", 8'h00, pc);
    chk("core clock after reset", 1, core_clk_en);
    enter({`MODE_PD, 1'b1}, 1'b1);
    @(posedge mclk);
    external_interrupt_zero_is_level <= 1'b1;
    wake(5, 12);
    // comparator powered down no longer wakes idle
    bus(1'b1, `IDX_CMP, 32'h80);
    rdc("cmp ctl", `IDX_CMP, 32'h80);
    chk("cmp power", 0, cmp_pwr_en);
    enter({`MODE_IDLE, 1'b1}, 1'b1);
    @(posedge mclk);
    wsrc[6] <= 1'b1;
    repeat (10) @(negedge mclk);
    chk("cmp no wake", 1, sleeping);
    @(posedge mclk);
    wsrc[6] <= 1'b0;
    wake(0, 7);
    // synchronous timer two keeps its own clock and still wakes power-save
    @(posedge mclk);
    t2_async <= 1'b0;
    enter({`MODE_PS, 1'b1}, 1'b1);
    chk("t2 sync clock on", 1, t2_sync_clk_en);
    chk("timer osc off", 0, timer_osc_en);
    wake(3, 12);
    report_and_stop();
  end
endmodule
